// [design/mdso_pkg.sv]
// Purpose: constants and carrier types of the motor driver status outputs
// Assumes: 125 MHz reference clock, 8-bit byte addresses on a 32-bit register port
// Notes: timing counts derive from times given in their own units
`default_nettype none

package mdso_pkg;

    // Clock and speed pulse timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned SPD_PULSE_NS = 200000;
    localparam int unsigned SPD_PULSE_CYC = SPD_PULSE_NS / CLK_PERIOD_NS;
    localparam int unsigned PULSES_PER_REV = 30;

    // Widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SPEED_W = 12;
    localparam int unsigned WIDTH_W = 9;
    localparam int unsigned NOTICE_N = 19;
    localparam int unsigned INPUT_N = 16;
    localparam int unsigned GEN_N = 4;
    localparam int unsigned PIN_N = 7;

    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_VA_WIDTH = 8'h04;
    localparam logic [7:0] REG_NOTICE_APPLY = 8'h08;
    localparam logic [7:0] REG_GEN_CFG = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_NOTICE = 8'h14;
    localparam logic [7:0] REG_ECHO = 8'h18;

    // Field positions
    localparam int unsigned CTRL_DIR_BIT = 0;
    localparam int unsigned CTRL_AUTO_CLR_BIT = 1;
    localparam int unsigned GEN_HOST_LSB = 0;
    localparam int unsigned GEN_INV_LSB = 4;
    localparam int unsigned ECHO_NOTICE_CLR_IDX = 1;

    // Pin positions in the synchroniser vector
    localparam int unsigned PIN_STEP = 0;
    localparam int unsigned PIN_CW = 1;
    localparam int unsigned PIN_MAIN_PWR = 2;
    localparam int unsigned PIN_DIN_LSB = 3;

    // Reset values and limits
    localparam logic RST_DIR_SETTING = 1'b1;
    localparam logic RST_AUTO_CLR = 1'b1;
    localparam logic [8:0] RST_VA_WIDTH = 9'h0C8;
    localparam logic [8:0] VA_WIDTH_MIN = 9'h001;
    localparam logic [8:0] VA_WIDTH_MAX = 9'h190;
    localparam logic [18:0] RST_NOTICE_APPLY = 19'h7FFFF;

    // General signal routing carrier
    typedef struct packed {
        logic [3:0] invert;
        logic [3:0] host_bits;
    } mdso_gen_cfg_t;

    // Register port request carrier
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } mdso_bus_req_t;

endpackage : mdso_pkg

`default_nettype wire

// [design/mdso_top.sv]
// Purpose: status outputs of a brushless motor driver
// Assumes: rotation sensor gives one step edge per 1/30 revolution
// Notes: all status outputs are registered on I_REF_CLK
`default_nettype none

module mdso_top #(
    parameter int unsigned P_SPD_PULSE_CYC = mdso_pkg::SPD_PULSE_CYC
) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    // Register port
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WR_DATA,
    input wire logic I_WR_STB,
    input wire logic I_RD_STB,
    output logic [31:0] O_RD_DATA,
    // Pins from the motor and terminals
    input wire logic I_ROT_STEP,
    input wire logic I_ROT_CW,
    input wire logic I_MAIN_PWR,
    input wire logic [3:0] I_DIRECT_TERMINAL_IN,
    // Driver internal state
    input wire logic I_ALARM,
    input wire logic I_TORQUE_CLAMP,
    input wire logic I_OPERATION_ACTIVE,
    input wire logic [11:0] I_CMD_SPEED,
    input wire logic [11:0] I_FB_SPEED,
    input wire logic [18:0] I_NOTICE_CAUSE,
    input wire logic [15:0] I_INPUT_STATE,
    input wire logic I_MAINT_RUNNING,
    input wire logic I_TOOL_RUNNING,
    // Requests gated by busy
    input wire logic I_OPDATA_WR_REQ,
    input wire logic I_MAINT_REQ,
    output logic O_OPDATA_WR_GRANT,
    output logic O_MAINT_START,
    // Status outputs
    output logic O_SPEED_PULSE,
    output logic O_FAULT_NO_OUT,
    output logic O_FAULT_NC_OUT,
    output logic O_TORQUE_CLAMPED_OUT,
    output logic O_ROT_FWD,
    output logic O_MOTION,
    output logic O_NOTICE_ANY_OUT,
    output logic O_SPEED_ATTAINED_OUT,
    output logic [18:0] O_NOTICE_BITS,
    output logic O_SYSTEM_BUSY_OUT,
    output logic O_MAIN_POWER_PRESENT_OUT,
    output logic [15:0] O_INPUT_ECHO,
    // General signals
    output logic [3:0] O_DIRECT_TERMINAL_OUT,
    output logic [3:0] O_HOST_BIT_OUT
);

    localparam int unsigned CNT_W = $clog2(P_SPD_PULSE_CYC + 1);

    mdso_pkg::mdso_bus_req_t bus;
    mdso_pkg::mdso_gen_cfg_t gen_cfg_ff;

    logic [6:0] sync1_ff;
    logic [6:0] sync2_ff;
    logic [6:0] sync3_ff;
    logic [6:0] pin_ff;
    logic step_d_ff;
    logic step_evt;
    logic [CNT_W-1:0] pulse_cnt_ff;
    logic speed_pulse_ff;
    logic dir_setting_ff;
    logic auto_clr_ff;
    logic [8:0] va_width_ff;
    logic [18:0] notice_apply_ff;
    logic [18:0] notice_ff;
    logic [18:0] nxt_notice;
    logic clr_d_ff;
    logic clr_edge;
    logic fault_no_ff;
    logic fault_nc_ff;
    logic torque_ff;
    logic fwd_ff;
    logic motion_ff;
    logic notice_any_ff;
    logic attained_ff;
    logic busy_ff;
    logic mpwr_ff;
    logic [15:0] echo_ff;
    logic [3:0] dout_ff;
    logic [3:0] hbit_ff;
    logic [31:0] rd_data_ff;
    logic [12:0] speed_diff;

    assign bus = '{addr: I_ADDR, wdata: I_WR_DATA, wr: I_WR_STB, rd: I_RD_STB};

    // Out-of-range widths are clamped rather than refused
    function automatic logic [8:0] clamp_width(input logic [31:0] v);
        if (v[31:9] != 23'h000000 || v[8:0] > mdso_pkg::VA_WIDTH_MAX) begin
            return mdso_pkg::VA_WIDTH_MAX;
        end
        if (v[8:0] < mdso_pkg::VA_WIDTH_MIN) begin
            return mdso_pkg::VA_WIDTH_MIN;
        end
        return v[8:0];
    endfunction

    // Unsigned distance between two speeds, one bit wider
    function automatic logic [12:0] abs_diff(input logic [11:0] a, input logic [11:0] b);
        if (a >= b) begin
            return {1'b0, a - b};
        end
        return {1'b0, b - a};
    endfunction

    // Pin synchronisers: a change counts once stages two and three agree
    // Glitches shorter than two cycles never reach pin_ff
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            sync1_ff <= 7'h00;
            sync2_ff <= 7'h00;
            sync3_ff <= 7'h00;
            pin_ff <= 7'h00;
        end else begin
            sync1_ff <= {I_DIRECT_TERMINAL_IN, I_MAIN_PWR, I_ROT_CW, I_ROT_STEP};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pin_ff <= (pin_ff & (sync2_ff ^ sync3_ff)) | (sync3_ff & ~(sync2_ff ^ sync3_ff));
        end
    end

    // Each step edge marks 1/30 of a revolution
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            step_d_ff <= 1'b0;
        end else begin
            step_d_ff <= pin_ff[mdso_pkg::PIN_STEP];
        end
    end

    assign step_evt = step_d_ff ^ pin_ff[mdso_pkg::PIN_STEP];

    // Speed pulse: fixed polarity, no host mapping exists for it
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pulse_cnt_ff <= '0;
            speed_pulse_ff <= 1'b0;
        end else begin
            if (step_evt) begin
                pulse_cnt_ff <= CNT_W'(P_SPD_PULSE_CYC - 1);
                speed_pulse_ff <= 1'b1;
            end else if (pulse_cnt_ff != '0) begin
                pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
            end else begin
                speed_pulse_ff <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            dir_setting_ff <= mdso_pkg::RST_DIR_SETTING;
            auto_clr_ff <= mdso_pkg::RST_AUTO_CLR;
            va_width_ff <= mdso_pkg::RST_VA_WIDTH;
            notice_apply_ff <= mdso_pkg::RST_NOTICE_APPLY;
            gen_cfg_ff <= '0;
        end else if (bus.wr) begin
            unique case (bus.addr)
                mdso_pkg::REG_CTRL: begin
                    dir_setting_ff <= bus.wdata[mdso_pkg::CTRL_DIR_BIT];
                    auto_clr_ff <= bus.wdata[mdso_pkg::CTRL_AUTO_CLR_BIT];
                end
                mdso_pkg::REG_VA_WIDTH: begin
                    va_width_ff <= clamp_width(bus.wdata);
                end
                mdso_pkg::REG_NOTICE_APPLY: begin
                    notice_apply_ff <= bus.wdata[18:0];
                end
                mdso_pkg::REG_GEN_CFG: begin
                    gen_cfg_ff.host_bits <= bus.wdata[mdso_pkg::GEN_HOST_LSB +: 4];
                    gen_cfg_ff.invert <= bus.wdata[mdso_pkg::GEN_INV_LSB +: 4];
                end
                default: begin
                end
            endcase
        end
    end

    // Rotation sense, taken only from measured steps
    // Holds while stopped, since only a step event can move it
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            fwd_ff <= 1'b0;
        end else if (step_evt) begin
            fwd_ff <= ~(pin_ff[mdso_pkg::PIN_CW] ^ dir_setting_ff);
        end
    end

    // Notice latching; a new cause wins over a clear in the same cycle
    assign clr_edge = I_INPUT_STATE[mdso_pkg::ECHO_NOTICE_CLR_IDX] & ~clr_d_ff;

    always_comb begin
        if (auto_clr_ff) begin
            nxt_notice = I_NOTICE_CAUSE;
        end else if (clr_edge) begin
            nxt_notice = I_NOTICE_CAUSE;
        end else begin
            nxt_notice = I_NOTICE_CAUSE | notice_ff;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            clr_d_ff <= 1'b0;
            notice_ff <= 19'h00000;
            notice_any_ff <= 1'b0;
        end else begin
            clr_d_ff <= I_INPUT_STATE[mdso_pkg::ECHO_NOTICE_CLR_IDX];
            notice_ff <= nxt_notice;
            notice_any_ff <= |(notice_ff & notice_apply_ff);
        end
    end

    // Speed attained window
    assign speed_diff = abs_diff(I_FB_SPEED, I_CMD_SPEED);

    // Registered status outputs
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            fault_no_ff <= 1'b0;
            fault_nc_ff <= 1'b1;
            torque_ff <= 1'b0;
            motion_ff <= 1'b0;
            attained_ff <= 1'b0;
            busy_ff <= 1'b0;
            mpwr_ff <= 1'b0;
            echo_ff <= 16'h0000;
        end else begin
            fault_no_ff <= I_ALARM;
            fault_nc_ff <= ~I_ALARM;
            torque_ff <= I_TORQUE_CLAMP;
            motion_ff <= I_OPERATION_ACTIVE && (I_FB_SPEED != 12'h000);
            attained_ff <= speed_diff <= {4'h0, va_width_ff};
            busy_ff <= I_MAINT_RUNNING | I_TOOL_RUNNING;
            mpwr_ff <= pin_ff[mdso_pkg::PIN_MAIN_PWR];
            echo_ff <= I_INPUT_STATE;
        end
    end

    // General signals between host bits and direct terminals
    // Terminal inputs reuse the pin filter, so readback lags the pin
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            dout_ff <= 4'h0;
            hbit_ff <= 4'h0;
        end else begin
            dout_ff <= gen_cfg_ff.host_bits;
            hbit_ff <= pin_ff[mdso_pkg::PIN_DIN_LSB +: 4] ^ gen_cfg_ff.invert;
        end
    end

    // Busy refuses new maintenance and data rewrites
    // Gated by the registered busy, so the first running cycle still grants
    assign O_OPDATA_WR_GRANT = I_OPDATA_WR_REQ & ~busy_ff;
    assign O_MAINT_START = I_MAINT_REQ & ~busy_ff;

    // Read data stands for one cycle only, zero otherwise
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rd_data_ff <= 32'h00000000;
        end else if (bus.rd) begin
            unique case (bus.addr)
                mdso_pkg::REG_CTRL: begin
                    rd_data_ff <= {30'h00000000, auto_clr_ff, dir_setting_ff};
                end
                mdso_pkg::REG_VA_WIDTH: begin
                    rd_data_ff <= {23'h000000, va_width_ff};
                end
                mdso_pkg::REG_NOTICE_APPLY: begin
                    rd_data_ff <= {13'h0000, notice_apply_ff};
                end
                mdso_pkg::REG_GEN_CFG: begin
                    rd_data_ff <= {24'h000000, gen_cfg_ff};
                end
                mdso_pkg::REG_STATUS: begin
                    rd_data_ff <= {20'h00000, hbit_ff, mpwr_ff, busy_ff, attained_ff,
                        notice_any_ff, motion_ff, fwd_ff, torque_ff, fault_no_ff};
                end
                mdso_pkg::REG_NOTICE: begin
                    rd_data_ff <= {13'h0000, notice_ff};
                end
                mdso_pkg::REG_ECHO: begin
                    rd_data_ff <= {16'h0000, echo_ff};
                end
                default: begin
                    rd_data_ff <= 32'h00000000;
                end
            endcase
        end else begin
            rd_data_ff <= 32'h00000000;
        end
    end

    assign O_RD_DATA = rd_data_ff;
    assign O_SPEED_PULSE = speed_pulse_ff;
    assign O_FAULT_NO_OUT = fault_no_ff;
    assign O_FAULT_NC_OUT = fault_nc_ff;
    assign O_TORQUE_CLAMPED_OUT = torque_ff;
    assign O_ROT_FWD = fwd_ff;
    assign O_MOTION = motion_ff;
    assign O_NOTICE_ANY_OUT = notice_any_ff;
    assign O_SPEED_ATTAINED_OUT = attained_ff;
    assign O_NOTICE_BITS = notice_ff;
    assign O_SYSTEM_BUSY_OUT = busy_ff;
    assign O_MAIN_POWER_PRESENT_OUT = mpwr_ff;
    assign O_INPUT_ECHO = echo_ff;
    assign O_DIRECT_TERMINAL_OUT = dout_ff;
    assign O_HOST_BIT_OUT = hbit_ff;

endmodule // mdso_top

`default_nettype wire

// [testbench/mdso_partner.sv]
// Purpose: rotation sensor model standing at the far side of the status block
// Assumes: one step edge per 1/30 revolution of the output shaft
// Notes: step spacing of 32 cycles keeps short bench pulses apart
`default_nettype none

module mdso_partner (
    // Clock and control from the bench
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic i_cw,
    // Sensor pins
    output var logic o_step,
    output var logic o_cw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] div_ff = 5'h00;
    logic step_ff = 1'b0;
    logic cw_ff = 1'b0;
    assign o_step = step_ff;
    assign o_cw = cw_ff;
    // Shaft turns whatever the operation input says
    always @(posedge i_clk) begin
        cw_ff <= i_cw;
        if (i_run) div_ff <= div_ff + 5'h01;
        if (i_run && div_ff == 5'h1F) step_ff <= ~step_ff;
    end
endmodule // mdso_partner

`default_nettype wire

// [testbench/mdso_top_asserts.sv]
// Purpose: concurrent checks on the status block ports
// Assumes: single clock domain, asynchronous active-low reset
// Notes: pulse width bound is a minimum, since a new step may stretch it
`default_nettype none

module mdso_chk #(
    parameter int unsigned P_SPD_PULSE_CYC = 8
) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_ARST_N,
    // Watched inputs
    input wire logic I_ALARM,
    input wire logic I_TORQUE_CLAMP,
    input wire logic I_OPERATION_ACTIVE,
    input wire logic [11:0] I_CMD_SPEED,
    input wire logic [11:0] I_FB_SPEED,
    input wire logic [18:0] I_NOTICE_CAUSE,
    input wire logic [15:0] I_INPUT_STATE,
    input wire logic I_MAINT_RUNNING,
    input wire logic I_TOOL_RUNNING,
    // Watched outputs
    input wire logic O_OPDATA_WR_GRANT,
    input wire logic O_MAINT_START,
    input wire logic O_SPEED_PULSE,
    input wire logic O_FAULT_NO_OUT,
    input wire logic O_FAULT_NC_OUT,
    input wire logic O_TORQUE_CLAMPED_OUT,
    input wire logic O_ROT_FWD,
    input wire logic O_MOTION,
    input wire logic O_NOTICE_ANY_OUT,
    input wire logic O_SPEED_ATTAINED_OUT,
    input wire logic [18:0] O_NOTICE_BITS,
    input wire logic O_SYSTEM_BUSY_OUT,
    input wire logic [15:0] O_INPUT_ECHO
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);
    logic [15:0] hi_ff;
    // Saturating count of high cycles of the speed pulse
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) hi_ff <= 16'h0000;
        else if (!O_SPEED_PULSE) hi_ff <= 16'h0000;
        else if (hi_ff != 16'hFFFF) hi_ff <= hi_ff + 16'h0001;
    end
    pulse_width_a: assert property ($fell(O_SPEED_PULSE) |-> hi_ff >= P_SPD_PULSE_CYC)
        else $error("speed pulse too short");
    fault_pair_a: assert property (1 |=> O_FAULT_NO_OUT == $past(I_ALARM)
        && O_FAULT_NC_OUT == !$past(I_ALARM)) else $error("fault outputs wrong");
    torque_out_a: assert property (I_TORQUE_CLAMP |=> O_TORQUE_CLAMPED_OUT)
        else $error("torque clamp not shown");
    dir_hold_a: assert property ($changed(O_ROT_FWD) |-> O_SPEED_PULSE)
        else $error("direction changed without step");
    motion_out_a: assert property (I_OPERATION_ACTIVE && I_FB_SPEED != 12'h000
        |=> O_MOTION) else $error("motion missing");
    speed_hit_a: assert property (I_FB_SPEED == I_CMD_SPEED |=> O_SPEED_ATTAINED_OUT)
        else $error("attained missing");
    notice_set_a: assert property (1 |=> (O_NOTICE_BITS & $past(I_NOTICE_CAUSE))
        == $past(I_NOTICE_CAUSE)) else $error("notice bit missing");
    notice_sum_a: assert property (O_NOTICE_BITS == 19'h00000 |=> !O_NOTICE_ANY_OUT)
        else $error("summary without notice");
    busy_on_a: assert property (I_MAINT_RUNNING || I_TOOL_RUNNING
        |=> O_SYSTEM_BUSY_OUT) else $error("busy missing");
    busy_gate_a: assert property (O_SYSTEM_BUSY_OUT
        |-> !O_OPDATA_WR_GRANT && !O_MAINT_START) else $error("grant while busy");
    input_echo_a: assert property (1 |=> O_INPUT_ECHO == $past(I_INPUT_STATE))
        else $error("echo wrong");
endmodule // mdso_chk

bind mdso_top mdso_chk #(.P_SPD_PULSE_CYC(P_SPD_PULSE_CYC)) u_chk (
    .I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .I_ALARM(I_ALARM),
    .I_TORQUE_CLAMP(I_TORQUE_CLAMP), .I_OPERATION_ACTIVE(I_OPERATION_ACTIVE),
    .I_CMD_SPEED(I_CMD_SPEED), .I_FB_SPEED(I_FB_SPEED), .I_NOTICE_CAUSE(I_NOTICE_CAUSE),
    .I_INPUT_STATE(I_INPUT_STATE), .I_MAINT_RUNNING(I_MAINT_RUNNING),
    .I_TOOL_RUNNING(I_TOOL_RUNNING), .O_OPDATA_WR_GRANT(O_OPDATA_WR_GRANT),
    .O_MAINT_START(O_MAINT_START), .O_SPEED_PULSE(O_SPEED_PULSE),
    .O_FAULT_NO_OUT(O_FAULT_NO_OUT), .O_FAULT_NC_OUT(O_FAULT_NC_OUT),
    .O_TORQUE_CLAMPED_OUT(O_TORQUE_CLAMPED_OUT), .O_ROT_FWD(O_ROT_FWD),
    .O_MOTION(O_MOTION), .O_NOTICE_ANY_OUT(O_NOTICE_ANY_OUT),
    .O_SPEED_ATTAINED_OUT(O_SPEED_ATTAINED_OUT), .O_NOTICE_BITS(O_NOTICE_BITS),
    .O_SYSTEM_BUSY_OUT(O_SYSTEM_BUSY_OUT), .O_INPUT_ECHO(O_INPUT_ECHO)
);

`default_nettype wire

// [testbench/mdso_top_bench.sv]
// Purpose: self-checking bench for the motor driver status outputs
// Assumes: speed pulse width cut to 8 cycles for run time
// Notes: shaft steps come from the partner model, 32 cycles apart
`default_nettype none

module mdso_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, wr, rd, run, cw, step, pcw, alm, trq, op, pwr, mnt, tool, owr, mreq;
    logic [7:0] addr;
    logic [31:0] wd, rdata;
    logic [3:0] din, dout, hout;
    logic [11:0] cmd, fb;
    logic [18:0] cause, nbits;
    logic [15:0] ins, echo;
    logic gnt, mst, sp, sp_q, fno, fnc, tc, fwd, mov, nany, att, busy, mpp;
    int errors = 0;
    int cmp_count = 0;
    int rises = 0;

    mdso_top #(.P_SPD_PULSE_CYC(8)) dut (
        .I_REF_CLK(clk), .I_ARST_N(rst_n), .I_ADDR(addr), .I_WR_DATA(wd), .I_WR_STB(wr),
        .I_RD_STB(rd), .O_RD_DATA(rdata), .I_ROT_STEP(step), .I_ROT_CW(pcw),
        .I_MAIN_PWR(pwr), .I_DIRECT_TERMINAL_IN(din), .I_ALARM(alm), .I_TORQUE_CLAMP(trq),
        .I_OPERATION_ACTIVE(op), .I_CMD_SPEED(cmd), .I_FB_SPEED(fb), .I_NOTICE_CAUSE(cause),
        .I_INPUT_STATE(ins), .I_MAINT_RUNNING(mnt), .I_TOOL_RUNNING(tool),
        .I_OPDATA_WR_REQ(owr), .I_MAINT_REQ(mreq), .O_OPDATA_WR_GRANT(gnt),
        .O_MAINT_START(mst), .O_SPEED_PULSE(sp), .O_FAULT_NO_OUT(fno), .O_FAULT_NC_OUT(fnc),
        .O_TORQUE_CLAMPED_OUT(tc), .O_ROT_FWD(fwd), .O_MOTION(mov), .O_NOTICE_ANY_OUT(nany),
        .O_SPEED_ATTAINED_OUT(att), .O_NOTICE_BITS(nbits), .O_SYSTEM_BUSY_OUT(busy),
        .O_MAIN_POWER_PRESENT_OUT(mpp), .O_INPUT_ECHO(echo), .O_DIRECT_TERMINAL_OUT(dout),
        .O_HOST_BIT_OUT(hout)
    );
    mdso_partner shaft (.i_clk(clk), .i_run(run), .i_cw(cw), .o_step(step), .o_cw(pcw));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Pulses counted on the falling edge, where the output is settled
    always @(negedge clk) begin
        sp_q <= sp;
        if (sp === 1'b1 && sp_q === 1'b0) rises++;
    end

    task automatic tally_and_finish;
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr32(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd32(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    // Thirty steps, then time for the last pulse to end
    task automatic spin;
        @(posedge clk);
        run <= 1'b1;
        repeat (960) @(posedge clk);
        run <= 1'b0;
        w(24);
    endtask

    initial begin
        #80us;
        errors++;
        tally_and_finish();
    end

    initial begin
        {rst_n, wr, rd, run, cw, alm, trq, op, pwr, mnt, tool, owr, mreq} = 13'h0000;
        {addr, wd, din, cmd, fb, cause, ins} = 103'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        w(1);
        chk({fnc, fwd}, 2'b10);
        rd32(8'h00, 32'h3);
        rd32(8'h04, 32'hC8);
        rd32(8'h08, 32'h7FFFF);
        rd32(8'h0C, 32'h0);
        rd32(8'h20, 32'h0);
        @(posedge clk);
        alm <= 1'b1;
        trq <= 1'b1;
        w(2);
        chk({fno, fnc, tc}, 3'b101);
        rd32(8'h10, 32'h23);
        @(posedge clk);
        alm <= 1'b0;
        trq <= 1'b0;
        cw <= 1'b1;
        w(2);
        chk({fno, fnc, tc}, 3'b010);
        spin();
        chk({rises[30:0], fwd}, {31'd30, 1'b1});
        @(posedge clk);
        cw <= 1'b0;
        w(10);
        chk(fwd, 1'b1);
        spin();
        chk({rises[30:0], fwd}, {31'd60, 1'b0});
        wr32(8'h00, 32'h2);
        spin();
        chk({rises[30:0], fwd}, {31'd90, 1'b1});
        @(posedge clk);
        op <= 1'b1;
        fb <= 12'd100;
        cmd <= 12'd300;
        w(2);
        chk({mov, att}, 2'b11);
        @(posedge clk);
        fb <= 12'd99;
        w(2);
        chk({mov, att}, 2'b10);
        @(posedge clk);
        fb <= 12'd0;
        w(2);
        chk(mov, 1'b0);
        wr32(8'h04, 32'd500);
        rd32(8'h04, 32'h190);
        wr32(8'h04, 32'h0);
        rd32(8'h04, 32'h1);
        @(posedge clk);
        cause <= 19'h8;
        w(3);
        chk({nany, nbits}, 20'h80008);
        wr32(8'h08, 32'h7FFF7);
        w(2);
        chk(nany, 1'b0);
        wr32(8'h00, 32'h0);
        @(posedge clk);
        cause <= 19'h0;
        w(3);
        chk(nbits, 19'h8);
        @(posedge clk);
        ins <= 16'h0002;
        w(3);
        chk(nbits, 19'h0);
        @(posedge clk);
        ins <= 16'hA5C3;
        w(2);
        chk(echo, 16'hA5C3);
        rd32(8'h18, 32'hA5C3);
        @(posedge clk);
        owr <= 1'b1;
        mreq <= 1'b1;
        w(1);
        chk({gnt, mst}, 2'b11);
        @(posedge clk);
        mnt <= 1'b1;
        w(2);
        chk({busy, gnt, mst}, 3'b100);
        @(posedge clk);
        mnt <= 1'b0;
        tool <= 1'b1;
        w(2);
        chk(busy, 1'b1);
        @(posedge clk);
        tool <= 1'b0;
        pwr <= 1'b1;
        din <= 4'h2;
        w(8);
        chk({busy, mpp, hout}, 6'h12);
        wr32(8'h0C, 32'hF9);
        w(8);
        chk({dout, hout}, 8'h9D);
        tally_and_finish();
    end
endmodule // mdso_top_bench

`default_nettype wire
